/* File: design/swc_pkg.sv */
package swc_pkg;

   // Register addresses on the serial register port.
   localparam logic [6:0] ADDR_CTRL      = 7'h20;
   localparam logic [6:0] ADDR_QUANTA    = 7'h21;
   localparam logic [6:0] ADDR_SAMPLE    = 7'h22;
   localparam logic [6:0] ADDR_ID_HIGH   = 7'h23;
   localparam logic [6:0] ADDR_ID_UMID   = 7'h24;
   localparam logic [6:0] ADDR_ID_LMID   = 7'h25;
   localparam logic [6:0] ADDR_ID_LOW    = 7'h26;
   localparam logic [6:0] ADDR_MASK_HIGH = 7'h27;
   localparam logic [6:0] ADDR_DLC       = 7'h2B;
   localparam logic [6:0] ADDR_OPTION    = 7'h3A;
   localparam logic [6:0] ADDR_STATUS    = 7'h3B;

   // Values after power-on reset.
   localparam logic [7:0] RST_CTRL   = 8'h00;
   localparam logic [7:0] RST_QUANTA = 8'hA0;
   localparam logic [7:0] RST_SAMPLE = 8'h33;
   localparam logic [7:0] RST_ZERO   = 8'h00;

   // Field positions and writable bits.
   localparam int         CTRL_CAL_BIT   = 7;
   localparam int         CTRL_TRIM_HI   = 6;
   localparam int         CTRL_TRIM_LO   = 5;
   localparam int         CTRL_ALLOW_BIT = 4;
   localparam int         CTRL_VALID_BIT = 0;
   localparam logic [1:0] TRIM_UNLOCK    = 2'h3;
   localparam logic [7:0] CTRL_RMASK     = 8'hF1;
   localparam logic [7:0] SAMPLE_WMASK   = 8'h3F;
   localparam logic [7:0] ID_LOW_WMASK   = 8'h7F;
   localparam logic [7:0] DLC_WMASK      = 8'h0F;
   localparam int         ID_LOW_IDENT_LSB = 2;
   localparam int         ID_LOW_RTR_BIT = 1;
   localparam int         ID_LOW_IDE_BIT = 0;

   // Identifier compare masks.
   localparam logic [20:0] LOW_MASK_FILL = 21'h1FFFFF;
   localparam logic [28:0] STD_ID_CMP    = 29'h1FFC0000;

   // Serial frame layout.
   localparam int         SPI_FRAME_BITS = 16;
   localparam logic [4:0] SPI_ADDR_DONE  = 5'h08;
   localparam logic [4:0] SPI_FRAME_DONE = 5'h10;

   typedef struct packed {
      logic [28:0] ident;
      logic        ext;
      logic        remote;
      logic [3:0]  dlc;
   } swc_frame_t;

   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } swc_access_t;

endpackage

/* File: design/swc_spi_port.sv */
`timescale 1ns/1ps
module swc_spi_port #(
   parameter int FRAME_BITS = 16
) (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                sck_pin,
   input  wire logic                csn_pin,
   input  wire logic                mosi_pin,
   input  wire logic [7:0]          rdata,
   output      logic [6:0]          cur_addr,
   output      swc_pkg::swc_access_t access,
   output      logic                access_valid,
   output      logic                miso,
   output      logic                miso_oe_n
);
   import swc_pkg::*;

   if (FRAME_BITS != SPI_FRAME_BITS) begin : g_check
      $error("swc_spi_port serves 16-bit frames only");
   end

   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [2:0] filt_reg;
   logic [2:0] last_reg;
   logic [15:0] sh_reg;
   logic [4:0]  cnt_reg;
   logic [7:0]  tx_reg;

   // Pins pass three flops; a level counts once the second and third agree.
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            // All three flops start at the pin's idle level, so no false select follows reset.
            s1_reg[i]   <= (i == 1);
            s2_reg[i]   <= (i == 1);
            s3_reg[i]   <= (i == 1);
            filt_reg[i] <= (i == 1);
            last_reg[i] <= (i == 1);
         end else begin
            s1_reg[i]   <= (i == 0) ? mosi_pin : ((i == 1) ? csn_pin : sck_pin);
            s2_reg[i]   <= s1_reg[i];
            s3_reg[i]   <= s2_reg[i];
            last_reg[i] <= filt_reg[i];
            if (s2_reg[i] == s3_reg[i]) begin
               filt_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_act;
   assign sck_rise = filt_reg[2] & ~last_reg[2];
   assign sck_fall = ~filt_reg[2] & last_reg[2];
   assign cs_rise  = filt_reg[1] & ~last_reg[1];
   assign cs_act   = ~filt_reg[1];
   assign cur_addr = sh_reg[6:0];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_reg  <= 16'h0000;
         cnt_reg <= 5'h00;
      end else if (!cs_act) begin
         cnt_reg <= 5'h00;
      end else if (sck_rise && cnt_reg != SPI_FRAME_DONE) begin
         sh_reg  <= {sh_reg[14:0], filt_reg[0]};
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // Read data is loaded on the falling edge after the address byte.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_reg    <= 8'h00;
         miso      <= 1'b0;
         miso_oe_n <= 1'b1;
      end else begin
         miso_oe_n <= ~cs_act;
         if (!cs_act) begin
            miso <= 1'b0;
         end else if (sck_fall && cnt_reg == SPI_ADDR_DONE) begin
            miso   <= rdata[7];
            tx_reg <= {rdata[6:0], 1'b0};
         end else if (sck_fall && cnt_reg > SPI_ADDR_DONE) begin
            miso   <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         access       <= '0;
         access_valid <= 1'b0;
      end else begin
         access_valid <= cs_rise && cnt_reg == SPI_FRAME_DONE && sh_reg[15];
         if (cs_rise && cnt_reg == SPI_FRAME_DONE) begin
            access <= {sh_reg[15], sh_reg[14:8], sh_reg[7:0]};
         end
      end
   end

endmodule // swc_spi_port

/* File: design/swc_top.sv */
`timescale 1ns/1ps
module swc_top (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                spi_sck,
   input  wire logic                spi_csn_n,
   input  wire logic                spi_mosi,
   output      logic                spi_miso,
   output      logic                spi_miso_oe_n,
   input  wire logic                bus_transmit_input_pin,
   input  wire logic                normal_mode,
   input  wire logic                stop_mode,
   input  wire logic                wake_event,
   input  wire logic                bus_timeout_event,
   input  wire swc_pkg::swc_frame_t frame_in,
   input  wire logic                frame_in_valid,
   output      logic                bus_timeout_irq,
   output      logic                selective_wake_enable,
   output      logic                oscillator_calibration_on,
   output      logic                osc_trim_edge,
   output      logic                alt_receiver_enable,
   output      logic [7:0]          quanta_per_bit,
   output      logic [5:0]          sampling_fraction,
   output      logic                wake_frame_hit
);
   import swc_pkg::*;

   logic        cal_reg;
   logic [1:0]  trim_reg;
   logic        allow_reg;
   logic        valid_reg;
   logic [7:0]  id_high_reg;
   logic [7:0]  id_umid_reg;
   logic [7:0]  id_lmid_reg;
   logic [6:0]  id_low_reg;
   logic [7:0]  mask_high_reg;
   logic [3:0]  dlc_reg;
   logic        flag_reg;
   logic [7:0]  rdata;
   logic [6:0]  cur_addr;
   swc_access_t acc;
   logic        acc_wr;

   swc_spi_port #(
      .FRAME_BITS (SPI_FRAME_BITS)
   ) u_port (
      .clk          (clk),
      .arst_n       (arst_n),
      .sck_pin      (spi_sck),
      .csn_pin      (spi_csn_n),
      .mosi_pin     (spi_mosi),
      .rdata        (rdata),
      .cur_addr     (cur_addr),
      .access       (acc),
      .access_valid (acc_wr),
      .miso         (spi_miso),
      .miso_oe_n    (spi_miso_oe_n)
   );

   logic wr_ctrl;
   logic wr_data;
   logic trim_open;
   assign wr_ctrl   = acc_wr && acc.addr == ADDR_CTRL;
   assign wr_data   = acc_wr && ((acc.addr >= ADDR_QUANTA && acc.addr <= ADDR_MASK_HIGH)
                                 || acc.addr == ADDR_DLC || acc.addr == ADDR_OPTION);
   assign trim_open = trim_reg == TRIM_UNLOCK;

   // Read mux; reserved bits come back as zero.
   always_comb begin
      case (cur_addr)
         ADDR_CTRL: begin
            rdata = {cal_reg, trim_reg, allow_reg, 3'h0, valid_reg};
         end
         ADDR_QUANTA:    rdata = quanta_per_bit;
         ADDR_SAMPLE:    rdata = {2'h0, sampling_fraction};
         ADDR_ID_HIGH:   rdata = id_high_reg;
         ADDR_ID_UMID:   rdata = id_umid_reg;
         ADDR_ID_LMID:   rdata = id_lmid_reg;
         ADDR_ID_LOW:    rdata = {1'b0, id_low_reg};
         ADDR_MASK_HIGH: rdata = mask_high_reg;
         ADDR_DLC:       rdata = {4'h0, dlc_reg};
         ADDR_OPTION:    rdata = {7'h00, alt_receiver_enable};
         ADDR_STATUS:    rdata = {7'h00, flag_reg};
         default:        rdata = RST_ZERO;
      endcase
   end

   // Control register fields other than the valid bit.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_reg   <= RST_CTRL[CTRL_CAL_BIT];
         trim_reg  <= RST_CTRL[CTRL_TRIM_HI:CTRL_TRIM_LO];
         allow_reg <= RST_CTRL[CTRL_ALLOW_BIT];
      end else if (wr_ctrl) begin
         cal_reg   <= acc.data[CTRL_CAL_BIT];
         trim_reg  <= acc.data[CTRL_TRIM_HI:CTRL_TRIM_LO];
         allow_reg <= acc.data[CTRL_ALLOW_BIT];
      end
   end

   // Configuration data registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         quanta_per_bit    <= RST_QUANTA;
         sampling_fraction <= RST_SAMPLE[5:0];
         id_high_reg       <= RST_ZERO;
         id_umid_reg       <= RST_ZERO;
         id_lmid_reg       <= RST_ZERO;
         id_low_reg        <= RST_ZERO[6:0];
         mask_high_reg     <= RST_ZERO;
         dlc_reg           <= RST_ZERO[3:0];
      end else if (acc_wr) begin
         case (acc.addr)
            ADDR_QUANTA:    quanta_per_bit <= acc.data;
            ADDR_SAMPLE:    sampling_fraction <= acc.data[5:0] & SAMPLE_WMASK[5:0];
            ADDR_ID_HIGH:   id_high_reg <= acc.data;
            ADDR_ID_UMID:   id_umid_reg <= acc.data;
            ADDR_ID_LMID:   id_lmid_reg <= acc.data;
            ADDR_ID_LOW:    id_low_reg <= acc.data[6:0] & ID_LOW_WMASK[6:0];
            ADDR_MASK_HIGH: mask_high_reg <= acc.data;
            ADDR_DLC:       dlc_reg <= acc.data[3:0] & DLC_WMASK[3:0];
            default: begin
            end
         endcase
      end
   end

   // The option register only takes writes while the trim field is unlocked.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alt_receiver_enable <= 1'b0;
      end else if (acc_wr && acc.addr == ADDR_OPTION && trim_open) begin
         alt_receiver_enable <= acc.data[0];
      end
   end

   // Wake frame comparison.
   logic [28:0] cfg_ident;
   logic [28:0] cmp_mask;
   logic        hit_now;
   assign cfg_ident = {id_high_reg, id_umid_reg, id_lmid_reg,
                       id_low_reg[6:ID_LOW_IDENT_LSB]};
   assign cmp_mask  = {mask_high_reg, LOW_MASK_FILL}
                      & (id_low_reg[ID_LOW_IDE_BIT] ? '1 : STD_ID_CMP);
   assign hit_now   = frame_in_valid && valid_reg
                      && (((frame_in.ident ^ cfg_ident) & cmp_mask) == 29'h0)
                      && frame_in.ext == id_low_reg[ID_LOW_IDE_BIT]
                      && frame_in.remote == id_low_reg[ID_LOW_RTR_BIT]
                      && frame_in.dlc == dlc_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_frame_hit <= 1'b0;
      end else begin
         wake_frame_hit <= hit_now;
      end
   end

   // Valid bit: set by the host, cleared by hardware on wake or setup change.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_reg <= RST_CTRL[CTRL_VALID_BIT];
      end else if (hit_now || wake_event) begin
         valid_reg <= 1'b0;
      end else if (wr_data) begin
         valid_reg <= 1'b0;
      end else if (wr_ctrl) begin
         valid_reg <= acc.data[CTRL_VALID_BIT] & ~stop_mode;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         selective_wake_enable <= 1'b0;
      end else begin
         selective_wake_enable <= valid_reg;
      end
   end

   // Timeout flag is sticky; a new event beats a clear in the same cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= 1'b0;
      end else if (bus_timeout_event && valid_reg) begin
         flag_reg <= 1'b1;
      end else if (acc_wr && acc.addr == ADDR_STATUS && acc.data[0]) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_timeout_irq <= 1'b0;
      end else begin
         bus_timeout_irq <= flag_reg && allow_reg && valid_reg
                            && (normal_mode || stop_mode);
      end
   end

   // Trim edges from the transmit-data pin while calibration is active.
   logic txd_s1_reg;
   logic txd_s2_reg;
   logic txd_s3_reg;
   logic txd_filt_reg;
   logic cal_active;
   assign cal_active = cal_reg && trim_open;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txd_s1_reg   <= 1'b1;
         txd_s2_reg   <= 1'b1;
         txd_s3_reg   <= 1'b1;
         txd_filt_reg <= 1'b1;
      end else begin
         txd_s1_reg <= bus_transmit_input_pin;
         txd_s2_reg <= txd_s1_reg;
         txd_s3_reg <= txd_s2_reg;
         if (txd_s2_reg == txd_s3_reg) begin
            txd_filt_reg <= txd_s3_reg;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oscillator_calibration_on <= 1'b0;
         osc_trim_edge             <= 1'b0;
      end else begin
         oscillator_calibration_on <= cal_active;
         osc_trim_edge <= cal_active && txd_s2_reg == txd_s3_reg
                          && txd_s3_reg != txd_filt_reg;
      end
   end

   sequence s_stop_cfg_write;
      stop_mode && (wr_data || wr_ctrl);
   endsequence

   property p_stop_write_clears;
      @(posedge clk) disable iff (!arst_n)
      s_stop_cfg_write |=> !valid_reg;
   endproperty
   a_stop_write_clears: assert property (p_stop_write_clears)
      else $error("stop-mode write left the valid bit set");

   property p_option_locked;
      @(posedge clk) disable iff (!arst_n)
      $changed(alt_receiver_enable) |-> $past(trim_reg) == TRIM_UNLOCK;
   endproperty
   a_option_locked: assert property (p_option_locked)
      else $error("option register changed while locked");

   property p_cal_locked;
      @(posedge clk) disable iff (!arst_n)
      (!cal_reg || trim_reg != TRIM_UNLOCK) |=> !oscillator_calibration_on ##1 1;
   endproperty
   a_cal_locked: assert property (p_cal_locked)
      else $error("calibration active while locked or off");

   property p_irq_masked;
      @(posedge clk) disable iff (!arst_n)
      !allow_reg |=> !bus_timeout_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("timeout interrupt raised while masked");

   property p_flag_needs_enable;
      @(posedge clk) disable iff (!arst_n)
      $rose(flag_reg) |-> $past(valid_reg) && $past(bus_timeout_event);
   endproperty
   a_flag_needs_enable: assert property (p_flag_needs_enable)
      else $error("timeout flag set without selective wake");

   property p_ctrl_reserved;
      @(posedge clk) disable iff (!arst_n)
      cur_addr == ADDR_CTRL |-> rdata[3:1] == 3'h0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved)
      else $error("reserved control bits read nonzero");

   property p_hit_clears_valid;
      @(posedge clk) disable iff (!arst_n)
      wake_frame_hit |-> !valid_reg && $past(valid_reg) ##1 !selective_wake_enable;
   endproperty
   a_hit_clears_valid: assert property (p_hit_clears_valid)
      else $error("wake hit did not clear the valid bit");

   property p_dlc_mismatch;
      @(posedge clk) disable iff (!arst_n)
      (frame_in_valid && frame_in.dlc != dlc_reg) |=> !wake_frame_hit;
   endproperty
   a_dlc_mismatch: assert property (p_dlc_mismatch)
      else $error("wake hit despite length mismatch");

endmodule // swc_top

/* File: dv/swc_can_node.sv */
`timescale 1ns/1ps
module swc_can_node
   import swc_pkg::*;
(
   input  wire logic                clk,
   output      swc_pkg::swc_frame_t frame,
   output      logic                valid
);
   initial begin
      frame = '0;
      valid = 1'b0;
   end

   // After the frame the lines show the inverse, so a stale value never matches by luck.
   task automatic send(input swc_frame_t f);
      @(posedge clk);
      frame <= f;
      valid <= 1'b1;
      @(posedge clk);
      frame <= ~f;
      valid <= 1'b0;
   endtask
endmodule // swc_can_node

/* File: dv/swc_top_tb_top.sv */
`timescale 1ns/1ps
module swc_top_tb_top;
   import swc_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        sck = 1'b0;
   logic        csn_n = 1'b1;
   logic        mosi = 1'b0;
   logic        tx_pin = 1'b1;
   logic        normal_mode = 1'b1;
   logic        stop_mode = 1'b0;
   logic        wake_ev = 1'b0;
   logic        tmo_ev = 1'b0;
   logic        miso, miso_oe_n, irq, sw_en, cal_on, trim_edge, alt_en, hit, fvalid;
   logic [7:0]  quanta;
   logic [5:0]  samp;
   swc_frame_t  frame;
   logic [7:0]  exp_q[$];
   logic [7:0]  obs, v, m;
   logic [6:0]  a;
   logic [28:0] id;
   logic [3:0]  dl;
   logic [34:0] base;
   logic        seen;
   logic        oe_mid;
   event        obs_ev;
   int          error_cnt = 0;
   int          checked = 0;
   int          win = 0;
   int          i;

   always #50 clk = ~clk;

   swc_top swc_top_i (.clk(clk), .arst_n(arst_n), .spi_sck(sck), .spi_csn_n(csn_n),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n),
      .bus_transmit_input_pin(tx_pin), .normal_mode(normal_mode), .stop_mode(stop_mode),
      .wake_event(wake_ev), .bus_timeout_event(tmo_ev), .frame_in(frame),
      .frame_in_valid(fvalid), .bus_timeout_irq(irq), .selective_wake_enable(sw_en),
      .oscillator_calibration_on(cal_on), .osc_trim_edge(trim_edge),
      .alt_receiver_enable(alt_en), .quanta_per_bit(quanta), .sampling_fraction(samp),
      .wake_frame_hit(hit));

   swc_can_node swc_can_node_i (.clk(clk), .frame(frame), .valid(fvalid));

   task automatic give_verdict;
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] o, input logic [7:0] e);
      checked++;
      if (o !== e) begin
         error_cnt++;
         $display("MISMATCH %0t got %h want %h", $time, o, e);
      end
   endtask

   // Waiting one edge keeps two notes apart and lets the next stimulus start on an edge.
   task automatic note(input logic [7:0] o, input logic [7:0] e);
      exp_q.push_back(e);
      obs = o;
      ->obs_ev;
      @(posedge clk);
   endtask

   always @(obs_ev) chk(obs, exp_q.pop_front());

   // A frame may be answered one or two edges after it is taken, so three cycles are watched.
   always @(negedge clk) begin
      if (win > 0) begin
         seen = seen | (hit === 1'b1);
         win--;
         if (win == 0) chk({7'b0, seen}, exp_q.pop_front());
      end
      if (fvalid === 1'b1) begin
         win = 3;
         seen = 1'b0;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Each serial clock phase lasts six cycles to clear the input synchroniser.
   task automatic spi(input logic w, input logic [6:0] ad, input logic [7:0] d,
                      output logic [7:0] r);
      logic [15:0] f;
      int          j;
      f = {w, ad, d};
      r = 8'h00;
      @(posedge clk);
      csn_n <= 1'b0;
      for (j = 15; j >= 0; j--) begin
         mosi <= f[j];
         cyc(6);
         if (j < 8) r = {r[6:0], miso};
         if (j == 7) oe_mid = miso_oe_n;
         sck <= 1'b1;
         cyc(6);
         sck <= 1'b0;
      end
      cyc(6);
      csn_n <= 1'b1;
      cyc(12);
   endtask

   task automatic wr(input logic [6:0] ad, input logic [7:0] d);
      logic [7:0] q;
      spi(1'b1, ad, d, q);
   endtask

   task automatic rd(input logic [6:0] ad, input logic [7:0] e);
      logic [7:0] q;
      spi(1'b0, ad, 8'h00, q);
      note(q, e);
      note({7'b0, oe_mid}, 8'h00);
   endtask

   task automatic tmo(input logic e);
      logic s;
      s = 1'b0;
      @(posedge clk);
      tmo_ev <= 1'b1;
      @(posedge clk);
      tmo_ev <= 1'b0;
      repeat (5) begin
         @(posedge clk);
         s = s | (irq === 1'b1);
      end
      note({7'b0, s}, {7'b0, e});
      wr(ADDR_STATUS, 8'h01);
      note({7'b0, irq}, 8'h00);
   endtask

   task automatic send(input logic [34:0] f, input logic e, input logic arm);
      if (arm) wr(ADDR_CTRL, 8'h01);
      exp_q.push_back({7'b0, e});
      swc_can_node_i.send(f);
      cyc(5);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      give_verdict;
   end

   initial begin
      void'($urandom(32));
      cyc(20);
      arst_n <= 1'b1;
      cyc(2);
      note(quanta, RST_QUANTA);
      note({2'b0, samp}, RST_SAMPLE);
      note({7'b0, miso_oe_n}, 8'h01);
      for (i = 0; i < 8; i++) rd(ADDR_CTRL + 7'(i), i == 1 ? RST_QUANTA :
                                 i == 2 ? RST_SAMPLE : RST_ZERO);
      wr(7'h30, 8'hFF);
      rd(7'h30, 8'h00);
      for (a = ADDR_QUANTA; a <= ADDR_MASK_HIGH; a++) begin
         v = 8'($urandom);
         m = a == ADDR_SAMPLE ? SAMPLE_WMASK : a == ADDR_ID_LOW ? ID_LOW_WMASK : 8'hFF;
         wr(a, v);
         rd(a, v & m);
         if (a == ADDR_QUANTA) note(quanta, v);
         if (a == ADDR_SAMPLE) note({2'b0, samp}, v & m);
      end
      wr(ADDR_CTRL, 8'hFF);
      rd(ADDR_CTRL, CTRL_RMASK);
      note(sw_en, 8'h01);
      note(cal_on, 8'h01);
      @(posedge clk);
      wake_ev <= 1'b1;
      @(posedge clk);
      wake_ev <= 1'b0;
      rd(ADDR_CTRL, 8'hF0);
      for (i = 0; i < 4; i++) begin
         wr(ADDR_CTRL, {1'b1, i[1:0], 5'h00});
         note(cal_on, {7'b0, i == 3});
         tx_pin <= ~tx_pin;
         m = 8'h00;
         repeat (12) begin
            @(posedge clk);
            m = m + {7'b0, trim_edge === 1'b1};
         end
         note(m, {7'b0, i == 3});
         wr(ADDR_OPTION, 8'h01);
         note(alt_en, {7'b0, i == 3});
      end
      wr(ADDR_CTRL, 8'h60);
      note(cal_on, 8'h00);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_OPTION, 8'h00);
      note(alt_en, 8'h01);
      wr(ADDR_CTRL, 8'h11);
      tmo(1'b1);
      wr(ADDR_CTRL, 8'h01);
      tmo(1'b0);
      wr(ADDR_CTRL, 8'h10);
      tmo(1'b0);
      normal_mode <= 1'b0;
      wr(ADDR_CTRL, 8'h11);
      tmo(1'b0);
      stop_mode <= 1'b1;
      tmo(1'b1);
      wr(ADDR_CTRL, 8'h11);
      rd(ADDR_CTRL, 8'h10);
      stop_mode <= 1'b0;
      normal_mode <= 1'b1;
      id = 29'($urandom);
      dl = 4'($urandom);
      wr(ADDR_ID_HIGH, id[28:21]);
      wr(ADDR_ID_UMID, id[20:13]);
      wr(ADDR_ID_LMID, id[12:5]);
      wr(ADDR_ID_LOW, {1'b0, id[4:0], 2'b01});
      wr(ADDR_MASK_HIGH, 8'hFF);
      wr(ADDR_DLC, {4'h0, dl});
      base = {id, 2'b10, dl};
      send(base, 1'b1, 1'b1);
      note(sw_en, 8'h00);
      rd(ADDR_CTRL, 8'h00);
      for (i = 0; i < 35; i++) send(base ^ (35'h1 << i), 1'b0, 1'b1);
      wr(ADDR_MASK_HIGH, 8'h7F);
      send(base ^ (35'h1 << 34), 1'b1, 1'b1);
      send(base ^ (35'h1 << 27), 1'b0, 1'b1);
      wr(ADDR_ID_LOW, {1'b0, id[4:0], 2'b00});
      base[5] = 1'b0;
      send(base ^ (35'h1 << 6), 1'b1, 1'b1);
      send(base ^ (35'h1 << 23), 1'b1, 1'b1);
      send(base ^ (35'h1 << 24), 1'b0, 1'b1);
      wr(ADDR_QUANTA, RST_QUANTA);
      rd(ADDR_CTRL, 8'h00);
      send(base, 1'b0, 1'b0);
      give_verdict;
   end
endmodule // swc_top_tb_top
